// File: inc/dps_pkg.sv
package dps_pkg;
  localparam int          PIN_COUNT     = 32;
  localparam int          SYNC_STAGES   = 2;
  // primary jtag window, trace window, secondary jtag window
  localparam int          PRI_JTAG_BASE = 17;
  localparam int          PRI_JTAG_LAST = 21;
  localparam int          TRACE_BASE    = 22;
  localparam int          TRACE_WIDTH   = 10;
  localparam int          DBG_LAST      = 31;
  localparam int          SEC_JTAG_BASE = 27;
  // jtag pin order relative to window base
  localparam int          JTAG_TDO_OFS  = 0;
  localparam int          JTAG_TDI_OFS  = 1;
  localparam int          JTAG_TMS_OFS  = 2;
  localparam int          JTAG_TCK_OFS  = 3;
  localparam int          JTAG_TRST_OFS = 4;
  // pin function select 1 covers pins 16..31, two bits each
  localparam int          PFS1_FIRST_PIN = 16;
  localparam logic [31:0] PFS1_ADDR     = 32'hE002C004;
  localparam logic [31:0] PFS1_RESET    = 32'h00000000;
  localparam logic [31:0] PFS1_SEC_JTAG = 32'h55400000;
  localparam logic [1:0]  FUNC_ALT1     = 2'h1;
  // boot vector area
  localparam logic [31:0] VEC_BASE      = 32'h00000000;
  localparam logic [31:0] VEC_LAST      = 32'h0000001C;
  localparam logic [31:0] SIG_ADDR      = 32'h00000014;
  localparam logic [1:0]  STRAP_WAIT    = 2'(SYNC_STAGES);

  typedef enum {BOOT_HOLD, BOOT_STRAP, BOOT_CHECK, BOOT_USER, BOOT_ISP}
    dps_boot_t;
endpackage

// File: rtl/dps_sync.sv
`timescale 1ns/10ps
module dps_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= asyncIn;
      sync_reg <= meta_reg;
    end
  end

  assign syncOut = sync_reg;
endmodule

// File: rtl/dps_debug_pin_select_mux.sv
// Functional notes
// - debug-select high and test-clock strap high give pins 17..31 to debug.
// - primary mode: jtag on pins 17..21, trace on pins 22..31.
// - primary mode withholds pins 17..31 from the application.
// - either strap low at reset: no primary jtag and no trace pins.
// - software may put pins 27..31 in alternate function 1, secondary jtag.
// - with secondary jtag, pins 0..26 stay with the application.
// - boot starts user code only when the signature word is valid.
// - vectors sit at 0x00..0x1C; user code starts at address zero.
// - primary mode cannot change to secondary without a new reset.
// - writing 0x55400000 at 0xE002C004 selects secondary jtag pins.
`timescale 1ns/10ps
module dps_debug_pin_select_mux
  import dps_pkg::*;
(
  input  wire logic                              core_clk,
  input  wire logic                              rst_n,
  input  wire logic                              debugSelectPin,
  input  wire logic                              returnedTestClockPin,
  input  wire logic [dps_pkg::PIN_COUNT-1:0]     pinIn,
  output logic      [dps_pkg::PIN_COUNT-1:0]     pinOut,
  output logic      [dps_pkg::PIN_COUNT-1:0]     pinOe,
  input  wire logic [dps_pkg::PIN_COUNT-1:0]     gpioOut,
  input  wire logic [dps_pkg::PIN_COUNT-1:0]     gpioOe,
  output logic      [dps_pkg::PIN_COUNT-1:0]     gpioIn,
  input  wire logic                              cpuWrEn,
  input  wire logic [31:0]                       cpuWrAddr,
  input  wire logic [31:0]                       cpuWrData,
  input  wire logic                              jtagTdo,
  input  wire logic                              jtagTdoEn,
  output logic                                   jtagTck,
  output logic                                   jtagTms,
  output logic                                   jtagTdi,
  output logic                                   jtagTrstN,
  input  wire logic [dps_pkg::TRACE_WIDTH-1:0]   traceData,
  input  wire logic                              sigDone,
  input  wire logic                              sigValid,
  output logic      [31:0]                       sigAddr,
  output logic                                   userStart,
  output logic                                   userRun,
  output logic      [31:0]                       bootAddr,
  output logic                                   dbgPrimary,
  output logic                                   dbgSecondary
);
  import dps_pkg::*;

  typedef struct packed {
    dps_boot_t   boot;
    logic [1:0]  strapCnt;
    logic        primary;
    logic [31:0] pinFunctionSelect1;
    logic [31:0] pinOut;
    logic [31:0] pinOe;
    logic        tck;
    logic        tms;
    logic        tdi;
    logic        trstN;
    logic        userStart;
    logic        userRun;
    logic [31:0] bootAddr;
  } dps_state_t;

  dps_state_t state_reg;
  dps_state_t state_next;

  logic [PIN_COUNT+1:0] rawIn;
  logic [PIN_COUNT+1:0] syncIn;
  logic [PIN_COUNT-1:0] pinSync;
  logic                 dbgSelSync;
  logic                 testClkSync;

  assign rawIn = {debugSelectPin, returnedTestClockPin, pinIn};

  dps_sync #(.W(PIN_COUNT + 2)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .asyncIn  (rawIn),
    .syncOut  (syncIn)
  );

  assign pinSync     = syncIn[PIN_COUNT-1:0];
  assign testClkSync = syncIn[PIN_COUNT];
  assign dbgSelSync  = syncIn[PIN_COUNT+1];

  // two-bit function field of a pin in select register 1
  function automatic logic [1:0] pinFunc(input logic [31:0] sel,
                                         input int          pin);
    return sel[2*(pin-PFS1_FIRST_PIN) +: 2];
  endfunction

  function automatic logic inVectors(input logic [31:0] addr);
    return (addr >= VEC_BASE) && (addr <= VEC_LAST);
  endfunction

  logic secAll;
  always_comb begin
    secAll = 1'b1;
    for (int p = SEC_JTAG_BASE; p <= DBG_LAST; p++) begin
      secAll = secAll & (pinFunc(state_reg.pinFunctionSelect1, p) == FUNC_ALT1);
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.userStart = 1'b0;
    // select register loads in one cycle
    if (cpuWrEn && (cpuWrAddr == PFS1_ADDR)) begin
      state_next.pinFunctionSelect1 = cpuWrData;
    end
    unique case (state_reg.boot)
      BOOT_HOLD: begin
        state_next.boot     = BOOT_STRAP;
        state_next.strapCnt = '0;
      end
      BOOT_STRAP: begin
        if (state_reg.strapCnt == STRAP_WAIT) begin
          state_next.primary = dbgSelSync & testClkSync;
          state_next.boot    = BOOT_CHECK;
        end else begin
          state_next.strapCnt = state_reg.strapCnt + 2'h1;
        end
      end
      BOOT_CHECK: begin
        // user code only on valid signature
        if (sigDone) begin
          if (sigValid) begin
            state_next.boot      = BOOT_USER;
            state_next.userStart = 1'b1;
            state_next.userRun   = 1'b1;
            // execution begins at the vector base
            state_next.bootAddr  = VEC_BASE;
          end else begin
            state_next.boot = BOOT_ISP;
          end
        end
      end
      BOOT_USER: ;
      BOOT_ISP:  ;
    endcase

    // application keeps its pins by default
    state_next.pinOut = gpioOut;
    state_next.pinOe  = gpioOe;
    state_next.tck    = 1'b0;
    state_next.tms    = 1'b1;
    state_next.tdi    = 1'b1;
    state_next.trstN  = 1'b0;
    if (state_reg.primary) begin
      // whole debug window taken from the application
      for (int p = PRI_JTAG_BASE; p <= DBG_LAST; p++) begin
        state_next.pinOut[p] = 1'b0;
        state_next.pinOe[p]  = 1'b0;
      end
      state_next.pinOut[PRI_JTAG_BASE+JTAG_TDO_OFS] = jtagTdo;
      state_next.pinOe[PRI_JTAG_BASE+JTAG_TDO_OFS]  = jtagTdoEn;
      state_next.tdi   = pinSync[PRI_JTAG_BASE+JTAG_TDI_OFS];
      state_next.tms   = pinSync[PRI_JTAG_BASE+JTAG_TMS_OFS];
      state_next.tck   = pinSync[PRI_JTAG_BASE+JTAG_TCK_OFS];
      state_next.trstN = pinSync[PRI_JTAG_BASE+JTAG_TRST_OFS];
      for (int t = 0; t < TRACE_WIDTH; t++) begin
        state_next.pinOut[TRACE_BASE+t] = traceData[t];
        state_next.pinOe[TRACE_BASE+t]  = 1'b1;
      end
    end else begin
      // no primary or trace pins without both straps
      // per pin alternate function 1 routing
      for (int p = SEC_JTAG_BASE; p <= DBG_LAST; p++) begin
        if (pinFunc(state_reg.pinFunctionSelect1, p) == FUNC_ALT1) begin
          state_next.pinOut[p] = 1'b0;
          state_next.pinOe[p]  = 1'b0;
        end
      end
      if (pinFunc(state_reg.pinFunctionSelect1,
                  SEC_JTAG_BASE+JTAG_TDO_OFS) == FUNC_ALT1) begin
        state_next.pinOut[SEC_JTAG_BASE+JTAG_TDO_OFS] = jtagTdo;
        state_next.pinOe[SEC_JTAG_BASE+JTAG_TDO_OFS]  = jtagTdoEn;
      end
      // complete select pattern hands jtag to pins 27..31
      if (secAll) begin
        state_next.tdi   = pinSync[SEC_JTAG_BASE+JTAG_TDI_OFS];
        state_next.tms   = pinSync[SEC_JTAG_BASE+JTAG_TMS_OFS];
        state_next.tck   = pinSync[SEC_JTAG_BASE+JTAG_TCK_OFS];
        state_next.trstN = pinSync[SEC_JTAG_BASE+JTAG_TRST_OFS];
      end
    end

    if (!rst_n) begin
      state_next                    = '0;
      state_next.boot               = BOOT_HOLD;
      state_next.pinFunctionSelect1 = PFS1_RESET;
      state_next.tms                = 1'b1;
      state_next.tdi                = 1'b1;
      state_next.bootAddr           = VEC_BASE;
    end
  end

  // primary flag only written in strap capture, held to reset
  always_ff @(posedge core_clk) begin
    state_reg <= state_next;
  end

  assign pinOut       = state_reg.pinOut;
  assign pinOe        = state_reg.pinOe;
  assign gpioIn       = pinSync;
  assign jtagTck      = state_reg.tck;
  assign jtagTms      = state_reg.tms;
  assign jtagTdi      = state_reg.tdi;
  assign jtagTrstN    = state_reg.trstN;
  assign sigAddr      = SIG_ADDR;
  assign userStart    = state_reg.userStart;
  assign userRun      = state_reg.userRun;
  assign bootAddr     = state_reg.bootAddr;
  assign dbgPrimary   = state_reg.primary;
  assign dbgSecondary = !state_reg.primary && secAll;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_strap_capture: assert property (
    state_reg.boot == BOOT_STRAP && state_reg.strapCnt == STRAP_WAIT
    |=> state_reg.primary == $past(dbgSelSync && testClkSync))
    else $error("primary mode does not follow straps");
  a_trace_route: assert property (
    state_reg.primary |=> pinOut[DBG_LAST:TRACE_BASE] == $past(traceData)
                          && pinOe[DBG_LAST:TRACE_BASE] == '1)
    else $error("trace not on pins 22..31");
  a_pri_withheld: assert property (
    state_reg.primary |=> pinOe[PRI_JTAG_LAST:PRI_JTAG_BASE+1] == '0)
    else $error("application drives primary jtag inputs");
  a_no_trace: assert property (
    !state_reg.primary |=> pinOut[SEC_JTAG_BASE-1:TRACE_BASE]
                           == $past(gpioOut[SEC_JTAG_BASE-1:TRACE_BASE]))
    else $error("trace pins taken without primary mode");
  a_sec_tdo: assert property (
    !state_reg.primary && pinFunc(state_reg.pinFunctionSelect1,
                                  SEC_JTAG_BASE) == FUNC_ALT1
    |=> pinOut[SEC_JTAG_BASE] == $past(jtagTdo)
        && pinOe[SEC_JTAG_BASE] == $past(jtagTdoEn))
    else $error("secondary tdo not routed");
  a_app_pins: assert property (
    !state_reg.primary |=> pinOe[SEC_JTAG_BASE-1:0]
                           == $past(gpioOe[SEC_JTAG_BASE-1:0]))
    else $error("application pins 0..26 lost");
  a_sig_gate: assert property (
    state_reg.boot == BOOT_CHECK && sigDone && !sigValid
    |=> !userStart && !userRun [*2])
    else $error("user code started without signature");
  a_vec_start: assert property (
    userStart |-> bootAddr == VEC_BASE && inVectors(bootAddr)
                  && $past(state_reg.boot) == BOOT_CHECK)
    else $error("user code not started at vector base");
  a_mode_locked: assert property (
    state_reg.boot != BOOT_STRAP |=> $stable(state_reg.primary))
    else $error("debug mode changed without reset");
  a_sec_select: assert property (
    cpuWrEn && cpuWrAddr == PFS1_ADDR && cpuWrData == PFS1_SEC_JTAG
    && !state_reg.primary && state_reg.boot != BOOT_STRAP
    |=> dbgSecondary)
    else $error("secondary jtag not selected by write");
  a_sel_update: assert property (
    cpuWrEn && cpuWrAddr == PFS1_ADDR
    |=> state_reg.pinFunctionSelect1 == $past(cpuWrData))
    else $error("select write not taken next cycle");

  c_primary:   cover property (state_reg.primary && userRun);
  c_secondary: cover property (dbgSecondary ##1 jtagTck);
  c_user:      cover property (userStart);
  c_isp:       cover property (state_reg.boot == BOOT_ISP);
endmodule

// File: verification/dps_probe_model.sv
`timescale 1ns/10ps
module dps_probe_model (
  input  wire logic core_clk,
  input  wire logic run,
  input  wire logic holdDbg,
  input  wire logic holdRtck,
  output logic      strapDbg,
  output logic      strapRtck,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trstN
);
  logic [3:0] cnt;
  assign strapDbg  = holdDbg;
  assign strapRtck = holdRtck;
  initial begin
    cnt   = 4'h0;
    tck   = 1'b0;
    tms   = 1'b1;
    tdi   = 1'b1;
    trstN = 1'b0;
  end
  // lines hold still between frames
  always @(posedge core_clk) begin
    #2;
    if (run) begin
      cnt   <= cnt + 4'h1;
      tck   <= ~tck;
      tms   <= cnt[2];
      tdi   <= cnt[0];
      trstN <= 1'b1;
    end
  end
endmodule

// File: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import dps_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        run = 1'b0;
  logic        holdDbg = 1'b0;
  logic        holdRtck = 1'b0;
  logic        strapDbg, strapRtck, tck, tms, tdi, trstN;
  logic [31:0] pinIn, pinOut, pinOe, gpioOut, gpioOe, gpioIn;
  logic        cpuWrEn, jtagTdo, jtagTdoEn, sigDone, sigValid;
  logic [31:0] cpuWrAddr, cpuWrData, sigAddr, bootAddr;
  logic        jtagTck, jtagTms, jtagTdi, jtagTrstN;
  logic        userStart, userRun, dbgPrimary, dbgSecondary;
  logic [9:0]  traceData;
  int          errors = 0;
  int          compares = 0;
  int          starts;
  // dbg, returned_test_clock_pin, signature valid, primary expected
  logic [3:0]  rows [4] = '{4'b1111, 4'b0110, 4'b1000, 4'b0010};

  always #5 core_clk = ~core_clk;
  // probe wired to both jtag windows
  assign pinIn = {trstN, tck, tms, tdi, 1'b1, 5'h15,
                  trstN, tck, tms, tdi, 1'b1, 17'h0A5A5};

  dps_probe_model PROBE (.core_clk(core_clk), .run(run), .holdDbg(holdDbg),
    .holdRtck(holdRtck), .strapDbg(strapDbg), .strapRtck(strapRtck),
    .tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN));

  dps_debug_pin_select_mux DUT (.core_clk(core_clk), .rst_n(rst_n),
    .debugSelectPin(strapDbg), .returnedTestClockPin(strapRtck),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .gpioOut(gpioOut),
    .gpioOe(gpioOe), .gpioIn(gpioIn), .cpuWrEn(cpuWrEn),
    .cpuWrAddr(cpuWrAddr), .cpuWrData(cpuWrData), .jtagTdo(jtagTdo),
    .jtagTdoEn(jtagTdoEn), .jtagTck(jtagTck), .jtagTms(jtagTms),
    .jtagTdi(jtagTdi), .jtagTrstN(jtagTrstN), .traceData(traceData),
    .sigDone(sigDone), .sigValid(sigValid), .sigAddr(sigAddr),
    .userStart(userStart), .userRun(userRun), .bootAddr(bootAddr),
    .dbgPrimary(dbgPrimary), .dbgSecondary(dbgSecondary));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic summarize;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    cpuWrEn   = 1'b1;
    cpuWrAddr = addr;
    cpuWrData = data;
    step(1);
    cpuWrEn = 1'b0;
    step(1);
  endtask

  task automatic doReset(input logic d, input logic r, input logic v);
    rst_n    = 1'b0;
    holdDbg  = d;
    holdRtck = r;
    sigValid = v;
    step(4);
    rst_n  = 1'b1;
    starts = 0;
    repeat (10) begin
      step(1);
      starts += int'(userStart);
    end
  endtask

  task automatic route(input logic prim);
    if (prim) begin
      chk(pinOut[16:0], gpioOut[16:0]);
      chk(pinOe[16:0], gpioOe[16:0]);
      chk(pinOut[31:22], traceData);
      chk(pinOe[31:17], {10'h3FF, 4'h0, jtagTdoEn});
      chk(pinOut[17], jtagTdo);
    end else begin
      chk(pinOut, gpioOut);
      chk(pinOe, gpioOe);
    end
  endtask

  task automatic probe(input int n);
    run = 1'b1;
    step(n);
    run = 1'b0;
    step(4);
    chk({jtagTrstN, jtagTck, jtagTms, jtagTdi}, {trstN, tck, tms, tdi});
  endtask

  initial begin
    gpioOut   = 32'hC3A5_0F96;
    gpioOe    = 32'hF0F0_5A3C;
    cpuWrEn   = 1'b0;
    cpuWrAddr = 32'h0;
    cpuWrData = 32'h0;
    jtagTdo   = 1'b1;
    jtagTdoEn = 1'b1;
    traceData = 10'h2B5;
    sigDone   = 1'b1;
    sigValid  = 1'b0;
    step(1);
    for (int i = 0; i < 4; i++) begin
      doReset(rows[i][3], rows[i][2], rows[i][1]);
      chk(dbgPrimary, rows[i][0]);
      chk(userRun, rows[i][1]);
      chk(starts, rows[i][1]);
      chk(bootAddr, VEC_BASE);
      chk(sigAddr, SIG_ADDR);
      route(rows[i][0]);
      $display("strap row %0d done", i);
    end
    chk(gpioIn[16:0], 17'h0A5A5);
    wr(PFS1_ADDR + 32'h4, PFS1_SEC_JTAG);
    chk(dbgSecondary, 1'b0);
    route(1'b0);
    wr(PFS1_ADDR, PFS1_SEC_JTAG);
    chk(dbgSecondary, 1'b1);
    chk(pinOut[26:0], gpioOut[26:0]);
    chk(pinOe[26:0], gpioOe[26:0]);
    chk(pinOe[31:27], 5'h01);
    chk(pinOut[27], jtagTdo);
    jtagTdoEn = 1'b0;
    step(1);
    chk(pinOe[27], 1'b0);
    probe(8);
    probe(3);
    $display("secondary test done");
    doReset(1'b1, 1'b1, 1'b1);
    wr(PFS1_ADDR, PFS1_SEC_JTAG);
    step(1);
    chk(dbgPrimary, 1'b1);
    chk(dbgSecondary, 1'b0);
    route(1'b1);
    probe(5);
    $display("primary test done");
    // reset in mid-session drops every debug route
    rst_n = 1'b0;
    step(2);
    chk(pinOe, 32'h0000_0000);
    chk(dbgPrimary, 1'b0);
    chk(userRun, 1'b0);
    chk(jtagTrstN, 1'b0);
    $display("reset test done");
    summarize();
  end

  initial begin
    #50000;
    errors++;
    summarize();
  end
endmodule
